/* hw/potm_top.sv */
// Panel output stage: timing generator, pixel lane mapping, shift clocks,
// panel power controls and six display modes behind an APB register file.
// Assumes the sampled pixel stream is synchronous to pclk and that clock
// synthesis hardware outside consumes the lock enable and M/N divisors.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps

module potm_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [23:0] src_pixel_even,
    input  wire logic [23:0] src_pixel_odd,
    input  wire logic        input_timing_unstable,
    input  wire logic        board_test_enable,
    output logic             pixel_take,
    output logic [47:0]      panel_pixel_bus,
    output logic             panel_data_valid_out,
    output logic             panel_line_sync,
    output logic             panel_frame_start,
    output logic             panel_shift_clock_first,
    output logic             panel_shift_clock_second,
    output logic             panel_bias_on,
    output logic             panel_power_on,
    output logic             zoom_enable,
    output logic             synth_lock_enable,
    output logic [15:0]      synth_div_m,
    output logic [15:0]      synth_div_n
);

    typedef struct packed {
        logic [31:0]         ctrl;
        logic [31:0]         dest_h;
        logic [31:0]         dest_v;
        logic [31:0]         src_t;
        logic [31:0]         div;
        logic [31:0]         bg;
        potm_pkg::potm_mode_t mode_act;
        logic                fallback;
        logic [1:0]          slot;
        logic [11:0]         hcnt;
        logic [11:0]         vcnt;
        logic                clk_a;
        logic                clk_a_d;
        logic [47:0]         pdata;
        logic                de;
        logic                hs;
        logic                vs;
        logic [31:0]         rdata;
        logic                err;
    } potm_state_t;

    potm_state_t s;
    potm_state_t next_s;

    logic        two_pix;
    logic        eight;
    logic        tick;
    logic [11:0] htot;
    logic [11:0] vtot;
    logic [11:0] hact;
    logic [11:0] vact;
    logic        active;
    logic        use_input;
    logic        wrap_h;
    logic        wrap_v;
    logic [23:0] pix_e;
    logic [23:0] pix_o;
    logic [23:0] bar_e;
    logic [23:0] bar_o;
    logic        setup;
    logic        mapped;

    // Lane mapping of one or two 24-bit pixels onto the panel bus
    function automatic logic [47:0] potm_map(input logic [23:0] e, input logic [23:0] o,
                                             input logic two, input logic eb);
        logic [47:0] b;
        b = 48'h0000_0000_0000;
        b[5:0]   = e[23:18];
        b[11:6]  = e[15:10];
        b[17:12] = e[7:2];
        // Odd pixel lanes stay clear unless two pixels go out per clock
        if (two) begin
            b[23:18] = o[23:18];
            b[29:24] = o[15:10];
            b[35:30] = o[7:2];
        end
        if (eb) begin
            b[37:36] = e[17:16];
            b[39:38] = e[9:8];
            b[41:40] = e[1:0];
            if (two) begin
                b[43:42] = o[17:16];
                b[45:44] = o[9:8];
                b[47:46] = o[1:0];
            end
        end
        return b;
    endfunction

    // Format selection from the control register, timing selection from the active mode
    always_comb begin
        two_pix = s.ctrl[potm_pkg::CTRL_TWO_PIX];
        eight   = s.ctrl[potm_pkg::CTRL_EIGHT];
        // Source stand-alone paces lines and frames from source totals
        if (s.mode_act == potm_pkg::MODE_SRC_SA) begin
            htot = s.src_t[11:0];
            vtot = s.src_t[27:16];
        end else begin
            htot = s.dest_h[11:0];
            vtot = s.dest_v[11:0];
        end
        hact   = s.dest_h[27:16];
        vact   = s.dest_v[27:16];
        // Double pixel spends four cycles per slot, single pixel two
        tick   = two_pix ? (s.slot == 2'b11) : (s.slot == 2'b01);
        wrap_h = (s.hcnt + (two_pix ? 12'h002 : 12'h001)) >= htot;
        wrap_v = (s.vcnt + 12'h001) >= vtot;
        active = (s.vcnt != 12'h000) && (s.vcnt <= vact)
               && (s.hcnt >= potm_pkg::H_START)
               && (s.hcnt < potm_pkg::H_START + hact);
        case (s.mode_act)
            potm_pkg::MODE_NATIVE,
            potm_pkg::MODE_SLOW,
            potm_pkg::MODE_ZOOM,
            potm_pkg::MODE_DOWN:    use_input = 1'b1;
            default:                use_input = 1'b0;
        endcase
    end

    // Pattern generator colour bars and data source choice
    always_comb begin
        bar_e = {{8{s.hcnt[7]}}, {8{s.hcnt[6]}}, {8{s.hcnt[5]}}};
        bar_o = bar_e ^ 24'h00_00FF;
        case (s.mode_act)
            potm_pkg::MODE_DEST_SA: begin
                pix_e = s.bg[23:0];
                pix_o = s.bg[23:0];
            end
            potm_pkg::MODE_SRC_SA: begin
                pix_e = bar_e;
                pix_o = bar_o;
            end
            default: begin
                pix_e = src_pixel_even;
                pix_o = src_pixel_odd;
            end
        endcase
    end

    // Register decode helpers
    assign setup  = psel && !penable;
    assign mapped = (paddr == potm_pkg::CTRL_OFS) || (paddr == potm_pkg::DEST_H_OFS)
                 || (paddr == potm_pkg::DEST_V_OFS) || (paddr == potm_pkg::SRC_T_OFS)
                 || (paddr == potm_pkg::DIV_OFS) || (paddr == potm_pkg::BG_OFS)
                 || (paddr == potm_pkg::STATUS_OFS);

    // Next state: register file, mode latch, timing and panel outputs
    always_comb begin
        next_s = s;
        // APB write takes effect in the access phase
        if (psel && penable && pwrite) begin
            case (paddr)
                potm_pkg::CTRL_OFS:   next_s.ctrl   = pwdata & potm_pkg::CTRL_MASK;
                potm_pkg::DEST_H_OFS: next_s.dest_h = pwdata & potm_pkg::PAIR_MASK;
                potm_pkg::DEST_V_OFS: next_s.dest_v = pwdata & potm_pkg::PAIR_MASK;
                potm_pkg::SRC_T_OFS:  next_s.src_t  = pwdata & potm_pkg::PAIR_MASK;
                potm_pkg::DIV_OFS:    next_s.div    = pwdata;
                potm_pkg::BG_OFS:     next_s.bg     = pwdata & potm_pkg::BG_MASK;
                default:              next_s.err    = s.err;
            endcase
        end
        // Read data and error are captured in the setup phase
        if (setup) begin
            next_s.err = !mapped;
            case (paddr)
                potm_pkg::CTRL_OFS:   next_s.rdata = s.ctrl;
                potm_pkg::DEST_H_OFS: next_s.rdata = s.dest_h;
                potm_pkg::DEST_V_OFS: next_s.rdata = s.dest_v;
                potm_pkg::SRC_T_OFS:  next_s.rdata = s.src_t;
                potm_pkg::DIV_OFS:    next_s.rdata = s.div;
                potm_pkg::BG_OFS:     next_s.rdata = s.bg;
                potm_pkg::STATUS_OFS: next_s.rdata = {4'h0, s.vcnt, 11'h000, s.fallback,
                                                      board_test_enable, s.mode_act};
                default:              next_s.rdata = 32'h0000_0000;
            endcase
        end
        // Slot counter paces panel pixels
        next_s.slot = tick ? 2'b00 : s.slot + 2'b01;
        next_s.clk_a = two_pix ? next_s.slot[1] : next_s.slot[0];
        next_s.clk_a_d = s.clk_a;
        if (tick) begin
            next_s.hcnt = wrap_h ? 12'h000 : s.hcnt + (two_pix ? 12'h002 : 12'h001);
            if (wrap_h) begin
                next_s.vcnt = wrap_v ? 12'h000 : s.vcnt + 12'h001;
                // Frame boundary: new mode applies only here
                if (wrap_v) begin
                    next_s.fallback = s.ctrl[potm_pkg::CTRL_AUTO_SA]
                                    && input_timing_unstable;
                    if (next_s.fallback) begin
                        next_s.mode_act = potm_pkg::MODE_DEST_SA;
                    end else if (s.ctrl[2:0] > 3'b101) begin
                        next_s.mode_act = potm_pkg::MODE_NATIVE;
                    end else begin
                        next_s.mode_act = potm_pkg::potm_mode_t'(s.ctrl[2:0]);
                    end
                end
            end
            // Panel outputs launched on the slot boundary
            next_s.hs = s.hcnt < potm_pkg::HS_WIDTH;
            next_s.vs = (s.vcnt == 12'h000) && (s.hcnt < potm_pkg::HS_WIDTH);
            next_s.de = active;
            if (board_test_enable) begin
                next_s.pdata = s.hcnt[0] ? {12{4'hA}} : {12{4'h5}};
            end else if (active) begin
                next_s.pdata = potm_map(pix_e, pix_o, two_pix, eight);
            end else begin
                next_s.pdata = 48'h0000_0000_0000;
            end
        end
    end

    // State register, all state launched from one clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Clear all state, then load the register reset values
            s          <= '0;
            s.ctrl     <= potm_pkg::CTRL_RST;
            s.dest_h   <= potm_pkg::DEST_H_RST;
            s.dest_v   <= potm_pkg::DEST_V_RST;
            s.src_t    <= potm_pkg::SRC_T_RST;
            s.div      <= potm_pkg::DIV_RST;
            s.bg       <= potm_pkg::BG_RST;
            s.mode_act <= potm_pkg::MODE_NATIVE;
        end else begin
            s <= next_s;
        end
    end

    // Register read port; every access completes without wait states
    assign prdata                   = s.rdata;
    assign pready                   = 1'b1;
    assign pslverr                  = psel && penable && s.err;

    // Input pixel consumed at each active slot in the sampled-data modes
    assign pixel_take               = tick && active && use_input;

    // Panel data and timing registered on pclk; data valid is also gated directly by board_test_enable
    assign panel_pixel_bus          = s.pdata;
    assign panel_data_valid_out     = s.de && !board_test_enable;
    assign panel_line_sync          = s.hs;
    assign panel_frame_start        = s.vs;

    // Shift clocks: the second may lag one cycle and be inverted
    assign panel_shift_clock_first  = s.clk_a;
    assign panel_shift_clock_second = (s.ctrl[potm_pkg::CTRL_B_DLY] ? s.clk_a_d : s.clk_a)
                                    ^ s.ctrl[potm_pkg::CTRL_B_INV];

    // Panel power controls follow the control register directly
    assign panel_bias_on            = s.ctrl[potm_pkg::CTRL_BIAS];
    assign panel_power_on           = s.ctrl[potm_pkg::CTRL_POWER];

    // Zoom scaler runs only in zoom mode, never while downscaling
    assign zoom_enable              = (s.mode_act == potm_pkg::MODE_ZOOM);
    // Slow, zoom and downscaling need the synthesizer locked to the sample clock
    // Slow mode relies on that lower panel clock; no line buffer lives here
    // Divisors for a synthesizer fed from the 50 MHz reference
    assign synth_lock_enable        = (s.mode_act == potm_pkg::MODE_SLOW)
                                   || (s.mode_act == potm_pkg::MODE_ZOOM)
                                   || (s.mode_act == potm_pkg::MODE_DOWN);
    assign synth_div_m              = s.div[15:0];
    assign synth_div_n              = s.div[31:16];

endmodule

/* hw/potm_pkg.sv */
// Constants, register map and mode encoding for the panel output stage.
// Assumes a 32-bit APB register bus and a single 20 MHz clock.
package potm_pkg;

    // Clocking
    localparam int unsigned PCLK_HZ   = 20_000_000;
    localparam int unsigned REF_CLK_HZ = 50_000_000;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] DEST_H_OFS = 8'h04;
    localparam logic [7:0] DEST_V_OFS = 8'h08;
    localparam logic [7:0] SRC_T_OFS  = 8'h0C;
    localparam logic [7:0] DIV_OFS    = 8'h10;
    localparam logic [7:0] BG_OFS     = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TWO_PIX  = 3;
    localparam int CTRL_EIGHT    = 4;
    localparam int CTRL_B_INV    = 5;
    localparam int CTRL_B_DLY    = 6;
    localparam int CTRL_BIAS     = 7;
    localparam int CTRL_POWER    = 8;
    localparam int CTRL_AUTO_SA  = 9;

    // Writable bits of each register
    localparam logic [31:0] CTRL_MASK = 32'h0000_03FF;
    localparam logic [31:0] PAIR_MASK = 32'h0FFF_0FFF;
    localparam logic [31:0] BG_MASK   = 32'h00FF_FFFF;

    // Reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] DEST_H_RST = 32'h0280_0320;
    localparam logic [31:0] DEST_V_RST = 32'h01E0_020D;
    localparam logic [31:0] SRC_T_RST  = 32'h020D_0320;
    localparam logic [31:0] DIV_RST    = 32'h0001_0001;
    localparam logic [31:0] BG_RST     = 32'h0000_0000;

    // Line timing in panel pixels
    localparam logic [11:0] HS_WIDTH = 12'h008;
    localparam logic [11:0] H_START  = 12'h010;

    // Display modes
    typedef enum logic [2:0] {
        MODE_NATIVE  = 3'b000,
        MODE_SLOW    = 3'b001,
        MODE_ZOOM    = 3'b010,
        MODE_DOWN    = 3'b011,
        MODE_DEST_SA = 3'b100,
        MODE_SRC_SA  = 3'b101
    } potm_mode_t;

endpackage

/* bench/potm_checker.sv */
// Assertion checker for potm_top, attached by bind.
// Assumes APB writes complete when psel, penable and pready are high.
`timescale 1ns/1ps
module potm_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        board_test_enable,
    input wire logic        pixel_take,
    input wire logic [47:0] panel_pixel_bus,
    input wire logic        panel_data_valid_out,
    input wire logic        panel_line_sync,
    input wire logic        panel_frame_start,
    input wire logic        panel_shift_clock_first,
    input wire logic        panel_shift_clock_second,
    input wire logic        panel_bias_on,
    input wire logic        panel_power_on,
    input wire logic        zoom_enable,
    input wire logic        synth_lock_enable,
    input wire logic [15:0] synth_div_m,
    input wire logic [15:0] synth_div_n
);
    logic [31:0] sh_ctrl;
    logic [31:0] sh_div;
    logic [9:0]  quiet;
    logic        wr_ok;
    logic        calm;

    // Shadow of written settings; quiet counts cycles since the last control write
    assign wr_ok = psel && penable && pready && pwrite;
    assign calm  = quiet > 10'd599 && !board_test_enable && !sh_ctrl[9];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ctrl <= potm_pkg::CTRL_RST;
            sh_div  <= potm_pkg::DIV_RST;
            quiet   <= 10'h000;
        end else begin
            if (wr_ok && paddr == potm_pkg::CTRL_OFS)
                sh_ctrl <= pwdata & potm_pkg::CTRL_MASK;
            if (wr_ok && paddr == potm_pkg::DIV_OFS)
                sh_div <= pwdata;
            if (wr_ok && paddr == potm_pkg::CTRL_OFS)
                quiet <= 10'h000;
            else
                quiet <= quiet + {9'h000, quiet != 10'h3FF};
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Output relations
    AST_BIAS: assert property (panel_bias_on == sh_ctrl[7])
        else $error("Bias output differs from control");
    AST_POWER: assert property (panel_power_on == sh_ctrl[8])
        else $error("Power output differs from control");
    AST_DIV: assert property ({synth_div_n, synth_div_m} == sh_div)
        else $error("Divisor outputs differ from register");
    AST_CLK_SECOND: assert property (quiet > 10'd3 |-> panel_shift_clock_second == ((sh_ctrl[6] ?
        $past(panel_shift_clock_first) : panel_shift_clock_first) ^ sh_ctrl[5]))
        else $error("Second shift clock wrong");
    AST_CLK_SINGLE: assert property (calm && !sh_ctrl[3] |->
        panel_shift_clock_first != $past(panel_shift_clock_first))
        else $error("Single pixel shift clock not two cycles");
    AST_CLK_DOUBLE: assert property (calm && sh_ctrl[3] && $rose(panel_shift_clock_first) |=>
        panel_shift_clock_first ##1 !panel_shift_clock_first)
        else $error("Double pixel shift clock not four cycles");
    AST_ZOOM: assert property (calm |-> zoom_enable == (sh_ctrl[2:0] == 3'd2))
        else $error("Zoom enable wrong");
    AST_LOCK: assert property (calm |-> synth_lock_enable == (sh_ctrl[2:0] inside {3'd1, 3'd2, 3'd3}))
        else $error("Lock enable wrong");
    AST_DE_HS: assert property (panel_data_valid_out |-> !panel_line_sync)
        else $error("Data valid during line sync");
    AST_FS_HS: assert property (panel_frame_start |-> panel_line_sync)
        else $error("Frame start outside line sync");
    AST_FS_GAP: assert property ($fell(panel_frame_start) |-> !panel_frame_start [*8])
        else $error("Frame start repeated too soon");
    AST_TEST_DE: assert property (board_test_enable && $past(board_test_enable) |->
        !panel_data_valid_out)
        else $error("Data valid in test mode");
    AST_TEST_BUS: assert property (board_test_enable && $past(board_test_enable)
        && $past(board_test_enable, 5) |->
        panel_pixel_bus inside {48'hAAAA_AAAA_AAAA, 48'h5555_5555_5555})
        else $error("Test pattern missing on panel bus");
    AST_TAKE_SRC: assert property (calm && sh_ctrl[2:0] inside {3'd4, 3'd5} |->
        !pixel_take)
        else $error("Input pixel taken in a stand-alone mode");
    AST_TAKE_DE: assert property (pixel_take && !board_test_enable |=>
        panel_data_valid_out || board_test_enable)
        else $error("Taken pixel not shown as valid data");

    // Main scenarios
    cover property ($rose(panel_frame_start));
    cover property (zoom_enable);
    cover property (calm && sh_ctrl[3] && $rose(panel_shift_clock_first));
endmodule

bind potm_top potm_checker u_chk (.*);

/* bench/potm_panel_model.sv */
// Passive panel model: per-frame line, valid and cycle counts, lane compare.
// Assumes the bench supplies the expected bus word and arms the compare.
`timescale 1ns/1ps
module potm_panel_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [47:0] panel_pixel_bus,
    input  wire logic        panel_data_valid_out,
    input  wire logic        panel_line_sync,
    input  wire logic        panel_frame_start,
    input  wire logic [47:0] exp_bus,
    input  wire logic        arm,
    output int               lpf,
    output int               dpf,
    output int               cpf,
    output int               bad
);
    int   lc, dc, cc;
    logic hs_q, vs_q;

    // Statistics latched at each frame start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {lc, dc, cc, lpf, dpf, cpf, bad} <= '0;
            {hs_q, vs_q} <= 2'b00;
        end else begin
            hs_q <= panel_line_sync;
            vs_q <= panel_frame_start;
            if (panel_frame_start && !vs_q) begin
                {lpf, dpf, cpf} <= {lc, dc, cc};
                {lc, dc, cc} <= {32'h0, 32'h0, 32'h1};
            end else begin
                lc <= lc + int'(hs_q && !panel_line_sync);
                dc <= dc + int'(panel_data_valid_out);
                cc <= cc + 1;
            end
            if (arm && panel_data_valid_out && panel_pixel_bus !== exp_bus)
                bad <= bad + 1;
        end
    end
endmodule

/* bench/potm_top_tb.sv */
// Self-checking bench for potm_top: APB tasks, lane model, mode walk.
// Assumes the panel model is passive and the checker is bound to the design.
`timescale 1ns/1ps
module potm_top_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        input_timing_unstable = 1'b0, board_test_enable = 1'b0, arm = 1'b0;
    logic        pready, pslverr, panel_data_valid_out, panel_line_sync, panel_frame_start;
    logic        panel_shift_clock_first, panel_shift_clock_second, zoom_enable, er;
    logic        panel_bias_on, panel_power_on, synth_lock_enable, two, eight;
    logic [7:0]  paddr = 8'h00;
    logic [15:0] synth_div_m, synth_div_n;
    logic [23:0] src_pixel_even = 24'h0, src_pixel_odd = 24'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, ctl, seed = 32'h0000_134E;
    logic [47:0] panel_pixel_bus, exp_bus = 48'h0;
    int          fail_count = 0, cmp_count = 0, lpf, dpf, cpf, bad;
    logic [31:0] rv [8] = '{potm_pkg::CTRL_RST, potm_pkg::DEST_H_RST, potm_pkg::DEST_V_RST,
        potm_pkg::SRC_T_RST, potm_pkg::DIV_RST, potm_pkg::BG_RST, 32'h0, 32'h0};

    potm_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .src_pixel_even, .src_pixel_odd, .input_timing_unstable,
        .board_test_enable, .pixel_take(), .panel_pixel_bus, .panel_data_valid_out,
        .panel_line_sync, .panel_frame_start, .panel_shift_clock_first,
        .panel_shift_clock_second, .panel_bias_on, .panel_power_on, .zoom_enable,
        .synth_lock_enable, .synth_div_m, .synth_div_n);
    potm_panel_model u_panel (.pclk, .presetn, .panel_pixel_bus, .panel_data_valid_out,
        .panel_line_sync, .panel_frame_start, .exp_bus, .arm, .lpf, .dpf, .cpf, .bad);

    // Clock at 20 MHz
    initial begin
        forever #25 pclk = ~pclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Expected lanes: upper six bits per colour low, two low bits on top lanes
    function automatic logic [47:0] lanes(input logic [23:0] e, o, input logic tw, ei);
        logic [5:0] le, lo;
        le = ei ? {e[1:0], e[9:8], e[17:16]} : 6'h00;
        lo = ei ? {o[1:0], o[9:8], o[17:16]} : 6'h00;
        if (tw)
            return {lo, le, o[7:2], o[15:10], o[23:18], e[7:2], e[15:10], e[23:18]};
        return {6'h00, le, 18'h0, e[7:2], e[15:10], e[23:18]};
    endfunction

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_fs();
        int n;
        for (n = 0; n < 2000 && panel_frame_start !== 1'b0; n++) @(posedge pclk);
        for (n = 0; n < 2000 && panel_frame_start !== 1'b1; n++) @(posedge pclk);
        @(posedge pclk);
    endtask

    task automatic close_out();
        if (fail_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        close_out();
    end

    // Main sequence: registers, lane formats, mode walk, test mode, fallback
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, rd, er);
            chk(rd & (i == 6 ? 32'h0000_001F : 32'hFFFF_FFFF), rv[i]);
            chk(er, i == 7);
        end
        apb(1'b1, potm_pkg::DEST_H_OFS, 32'h0010_0028, rd, er);
        apb(1'b1, potm_pkg::DEST_V_OFS, 32'h0003_0006, rd, er);
        apb(1'b1, potm_pkg::SRC_T_OFS, 32'h0006_0028, rd, er);
        seed = xs(seed);
        apb(1'b1, potm_pkg::DIV_OFS, seed, rd, er);
        @(posedge pclk);
        chk({synth_div_n, synth_div_m}, seed);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF, rd, er);
        chk(er, 1'b1);
        wait_fs();
        for (int f = 0; f < 5; f++) begin
            two = f[0] || f == 4;
            eight = f[1] || f == 4;
            seed = xs(seed);
            ctl = xs(seed);
            src_pixel_even <= seed[23:0];
            src_pixel_odd <= ctl[23:0];
            if (f == 4)
                exp_bus <= lanes(ctl[23:0], ctl[23:0], 1'b1, 1'b1);
            else
                exp_bus <= lanes(seed[23:0], ctl[23:0], two, eight);
            seed = ctl;
            apb(1'b1, potm_pkg::BG_OFS, ctl, rd, er);
            ctl = {23'h0, ~two, two, f[1], f[0], eight, two, (f == 4 ? 3'd4 : 3'd0)};
            apb(1'b1, potm_pkg::CTRL_OFS, ctl, rd, er);
            wait_fs();
            arm <= 1'b1;
            wait_fs();
            arm <= 1'b0;
            chk(bad, 0);
            chk(dpf, 96);
            chk(lpf, 6);
            chk({panel_power_on, panel_bias_on}, {~two, two});
        end
        for (int m = 0; m < 7; m++) begin
            apb(1'b1, potm_pkg::CTRL_OFS, 32'(m), rd, er);
            apb(1'b0, potm_pkg::STATUS_OFS, 32'h0, rd, er);
            chk(rd[2:0], m == 0 ? 3'd4 : 3'(m - 1));
            wait_fs();
            wait_fs();
            chk(cpf, 480);
            chk(lpf, 6);
            apb(1'b0, potm_pkg::STATUS_OFS, 32'h0, rd, er);
            chk(rd[2:0], m == 6 ? 3'd0 : 3'(m));
            chk({zoom_enable, synth_lock_enable}, {m == 2, m > 0 && m < 4});
        end
        board_test_enable <= 1'b1;
        wait_fs();
        wait_fs();
        apb(1'b0, potm_pkg::STATUS_OFS, 32'h0, rd, er);
        chk(dpf, 0);
        chk(rd[3], 1'b1);
        board_test_enable <= 1'b0;
        apb(1'b1, potm_pkg::CTRL_OFS, 32'h0000_0200, rd, er);
        input_timing_unstable <= 1'b1;
        wait_fs();
        apb(1'b0, potm_pkg::STATUS_OFS, 32'h0, rd, er);
        chk(rd[4:0], 5'h14);
        close_out();
    end
endmodule
